// *** hw/rx_status_and_layer4_crc.sv ***
// Overview of operation
// - Bit 7: one when vertically corrected
// - Bit 6: block sync held at reception
// - Bit 5: frame sync held at reception
// - Bit 4: correction failed or layer-2 error
// - Bit 3: parity block, else data block
// - Bit 2: frame head block
// - Bit 1: mirrors check result pin
// - Bit 0: real-time block, method A' only
// - Block number: data 0-189, parity 0-81
// - Both registers reset to zero; status reads 02h as bit 1 is live
// - Registers load as interrupt falls
// - Serial read gives 8 status bits first, then the 8-bit block number
// - Option bit one: registers follow live state
// - Result high when check register all zero
// - Check polynomial x16+x12+x5+1
// - Bytes written at 6h feed the check
// - Interrupt goes low when block ready
`timescale 1ns/100ps
module rx_status_and_layer4_crc
  import rx_status_pkg::*;
#(
  parameter int ADDR_WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // Corrected-block side from the correction engines
  input wire logic block_ready,
  input wire logic block_done,
  input wire logic vertical_corrected_flag,
  input wire logic block_sync_flag,
  input wire logic frame_sync_flag,
  input wire logic correction_failed,
  input wire logic layer2_error,
  input wire logic parity_block_flag,
  input wire logic frame_head_flag,
  input wire logic realtime_block_flag,
  input wire logic [7:0] block_number_in,
  // Control bits from the write-register side
  input wire logic interrupt_timing_option,
  input wire logic upper_layer_check_clear,
  // Parallel register port
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Serial status port
  input wire logic serial_status_start,
  input wire logic serial_chip_enable,
  input wire logic serial_shift,
  output logic serial_out,
  output logic serial_status_done,
  // Pins
  output logic int_b,
  output logic upper_layer_check_ok
);
  // Parameter checks
  if (ADDR_WIDTH < 4) begin : g_addr_too_narrow
    $error("ADDR_WIDTH below 4 cannot reach every register");
  end
  if (SERIAL_STATUS_BITS != 16) begin : g_serial_length
    $error("Serial status word must hold status and block number");
  end

  // Reset copy
  logic rst_meta_b;
  logic rst_sync_b;

  // Interrupt and capture
  logic int_reg;
  logic int_next;
  logic load_event;
  logic capture_enable;
  logic [7:0] status_reg;
  logic [7:0] block_number_reg;
  logic [7:0] live_status;
  logic [7:0] shown_status;
  logic [7:0] shown_number;

  // Layer 4 check
  logic [15:0] check_reg;
  logic [15:0] check_next;

  // Register port
  logic status_read_hit;
  logic number_read_hit;
  logic check_write_hit;
  logic [7:0] rdata_next;

  // Serial status port
  typedef enum logic [1:0] {SER_IDLE, SER_STATUS, SER_DATA} ser_state_type;
  ser_state_type ser_state_reg;
  ser_state_type ser_state_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic [4:0] shift_count_reg;
  logic [4:0] shift_count_next;
  logic shift_load;
  logic shift_step;
  logic serial_out_next;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // One CRC step on a byte, MSB first
  function automatic logic [15:0] check_byte(input logic [15:0] crc,
                                             input logic [7:0] data);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CHECK_POLY;
      end
    end
    return c;
  endfunction : check_byte

  // Address match on the parallel port
  function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] addr,
                                    input logic [3:0] target);
    return addr == ADDR_WIDTH'(target);
  endfunction : addr_hit

  // Register port decoding
  always_comb begin
    status_read_hit = reg_read && addr_hit(reg_addr, STATUS_ADDR);
    number_read_hit = reg_read && addr_hit(reg_addr, BLOCK_NUMBER_ADDR);
    check_write_hit = reg_write && addr_hit(reg_addr, CHECK_DATA_ADDR);
  end

  // Interrupt low while a ready block awaits the host
  always_comb begin
    int_next = int_reg;
    if (block_ready) begin
      int_next = 1'b0;
    end else if (block_done) begin
      int_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      int_reg <= 1'b1;
    end else begin
      int_reg <= int_next;
    end
  end

  assign int_b = int_reg;
  assign load_event = int_reg & ~int_next;

  // Live status from the correction side
  always_comb begin
    live_status = STATUS_RESET;
    live_status[VERTICAL_BIT] = vertical_corrected_flag;
    live_status[BLOCK_SYNC_BIT] = block_sync_flag;
    live_status[FRAME_SYNC_BIT] = frame_sync_flag;
    live_status[ERROR_BIT] = correction_failed | layer2_error;
    live_status[PARITY_BIT] = parity_block_flag;
    live_status[HEAD_BIT] = frame_head_flag;
    live_status[REALTIME_BIT] = realtime_block_flag;
  end

  // Status and block number capture
  assign capture_enable = load_event | interrupt_timing_option;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status_reg <= STATUS_RESET;
    end else if (capture_enable) begin
      status_reg <= live_status;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      block_number_reg <= BLOCK_NUMBER_RESET;
    end else if (capture_enable) begin
      block_number_reg <= block_number_in;
    end
  end

  // Layer 4 check register, clear wins over a write
  always_comb begin
    check_next = check_reg;
    if (upper_layer_check_clear) begin
      check_next = CHECK_RESET;
    end else if (check_write_hit) begin
      check_next = check_byte(check_reg, reg_wdata);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      check_reg <= CHECK_RESET;
    end else begin
      check_reg <= check_next;
    end
  end

  assign upper_layer_check_ok = (check_reg == 16'h0000);

  // Host view: bit 1 is always live
  always_comb begin
    shown_status = status_reg;
    shown_status[CHECK_OK_BIT] = upper_layer_check_ok;
    shown_number = block_number_reg;
  end

  // Parallel read data, registered
  always_comb begin
    rdata_next = reg_rdata;
    if (status_read_hit) begin
      rdata_next = shown_status;
    end else if (number_read_hit) begin
      rdata_next = shown_number;
    end else if (reg_read) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // Serial status: 16 bits MSB first, chip enable low aborts
  always_comb begin
    ser_state_next = ser_state_reg;
    shift_load = 1'b0;
    shift_step = 1'b0;
    if (!serial_chip_enable) begin
      ser_state_next = SER_IDLE;
    end else begin
      case (ser_state_reg)
        SER_IDLE: begin
          if (serial_status_start) begin
            shift_load = 1'b1;
            ser_state_next = SER_STATUS;
          end
        end
        SER_STATUS: begin
          if (serial_shift) begin
            shift_step = 1'b1;
            if (shift_count_reg == 5'h01) begin
              ser_state_next = SER_DATA;
            end
          end
        end
        default: begin
          ser_state_next = SER_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ser_state_reg <= SER_IDLE;
    end else begin
      ser_state_reg <= ser_state_next;
    end
  end

  // Status word shifter
  always_comb begin
    shift_next = shift_reg;
    if (shift_load) begin
      shift_next = {shown_status, shown_number};
    end else if (shift_step) begin
      shift_next = {shift_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      shift_reg <= 16'h0000;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Bits left in the status word
  always_comb begin
    shift_count_next = shift_count_reg;
    if (!serial_chip_enable) begin
      shift_count_next = 5'h00;
    end else if (shift_load) begin
      shift_count_next = 5'(SERIAL_STATUS_BITS);
    end else if (shift_step) begin
      shift_count_next = shift_count_reg - 5'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      shift_count_reg <= 5'h00;
    end else begin
      shift_count_reg <= shift_count_next;
    end
  end

  // Wire bit, low outside the status word
  always_comb begin
    serial_out_next = 1'b0;
    if (ser_state_reg == SER_STATUS) begin
      serial_out_next = shift_reg[15];
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= serial_out_next;
    end
  end

  assign serial_status_done = (ser_state_reg == SER_DATA);
endmodule : rx_status_and_layer4_crc

// *** hw/rx_status_pkg.sv ***
package rx_status_pkg;
  // Register addresses, read side
  localparam logic [3:0] STATUS_ADDR = 4'h1;
  localparam logic [3:0] BLOCK_NUMBER_ADDR = 4'h2;
  // Register addresses, write side
  localparam logic [3:0] CHECK_DATA_ADDR = 4'h6;
  // Status bit positions
  localparam int VERTICAL_BIT = 7;
  localparam int BLOCK_SYNC_BIT = 6;
  localparam int FRAME_SYNC_BIT = 5;
  localparam int ERROR_BIT = 4;
  localparam int PARITY_BIT = 3;
  localparam int HEAD_BIT = 2;
  localparam int CHECK_OK_BIT = 1;
  localparam int REALTIME_BIT = 0;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BLOCK_NUMBER_RESET = 8'h00;
  localparam logic [15:0] CHECK_RESET = 16'h0000;
  // Generator x^16 + x^12 + x^5 + 1, top term implied
  localparam logic [15:0] CHECK_POLY = 16'h1021;
  // Highest legal block numbers
  localparam logic [7:0] DATA_BLOCK_MAX = 8'hbd;
  localparam logic [7:0] PARITY_BLOCK_MAX = 8'h51;
  // Serial status word length
  localparam int SERIAL_STATUS_BITS = 16;
endpackage : rx_status_pkg

// *** verification/host_model.sv ***
`timescale 1ns/100ps
module host_model (
  input wire logic core_clk,
  output logic [3:0] reg_addr,
  output logic reg_read,
  output logic reg_write,
  output logic [7:0] reg_wdata,
  output logic upper_layer_check_clear
);
  initial begin
    {reg_addr, reg_read, reg_write, reg_wdata} = 14'h0000;
    upper_layer_check_clear = 1'b0;
  end
  // One bus cycle; afterwards address and data show the inverse, strobes low
  task automatic cyc(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk) #1;
    {reg_addr, reg_wdata, reg_read, reg_write} = {a, d, !w, w};
    @(posedge core_clk) #1;
    {reg_addr, reg_wdata, reg_read, reg_write} = {~a, ~d, 2'b00};
  endtask : cyc
  task automatic clr();
    @(posedge core_clk) #1 upper_layer_check_clear = 1'b1;
    @(posedge core_clk) #1 upper_layer_check_clear = 1'b0;
  endtask : clr
endmodule : host_model

// *** verification/rx_status_asserts.sv ***
`timescale 1ns/100ps
module rx_status_asserts #(
  parameter int ADDR_WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic block_ready,
  input wire logic block_done,
  input wire logic block_sync_flag,
  input wire logic [7:0] block_number_in,
  input wire logic interrupt_timing_option,
  input wire logic upper_layer_check_clear,
  input wire logic [ADDR_WIDTH-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_chip_enable,
  input wire logic serial_status_done,
  input wire logic int_b,
  input wire logic upper_layer_check_ok
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_s = reg_read && reg_addr == 1;
  wire logic rd_n = reg_read && reg_addr == 2;
  wire logic quiet = !block_ready && !interrupt_timing_option;
  chk_int_falls: assert property (block_ready |=> !int_b)
    else $error("int_b did not fall");
  chk_int_holds: assert property (!int_b && !block_done |=> !int_b)
    else $error("int_b rose early");
  chk_clear_ok: assert property (
    upper_layer_check_clear |=> upper_layer_check_ok)
    else $error("check_ok low after clear");
  chk_live_bit: assert property (
    rd_s |=> reg_rdata[1] == $past(upper_layer_check_ok))
    else $error("status bit 1 wrong");
  chk_unmapped_zero: assert property (
    reg_read && reg_addr > 2 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_sync_capture: assert property (
    (block_ready && int_b) ##1 quiet [*2] ##0 rd_s
    |=> reg_rdata[6] == $past(block_sync_flag, 3))
    else $error("sync bit not captured");
  chk_number_capture: assert property (
    (block_ready && int_b) ##1 quiet [*2] ##0 rd_n
    |=> reg_rdata == $past(block_number_in, 3))
    else $error("number not captured");
  chk_serial_abort: assert property (!serial_chip_enable |=> !serial_status_done)
    else $error("serial done after abort");
  cov_block: cover property (block_ready ##1 !int_b);
  cov_serial: cover property ($rose(serial_status_done));
  cov_ok: cover property ($rose(upper_layer_check_ok));
endmodule : rx_status_asserts
bind rx_status_and_layer4_crc rx_status_asserts #(.ADDR_WIDTH(ADDR_WIDTH))
  rx_status_asserts_i (.*);

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import rx_status_pkg::*;
  logic core_clk = 0, rst_b = 0, block_ready = 0, block_done = 0, pend = 0;
  logic interrupt_timing_option = 0, serial_status_start = 0;
  logic serial_chip_enable = 0, serial_shift = 0, serial_out, int_b;
  logic serial_status_done, upper_layer_check_ok, upper_layer_check_clear;
  logic reg_read, reg_write;
  logic [3:0] reg_addr;
  logic [7:0] flags = 0, block_number_in = 0, reg_rdata, reg_wdata, e, d;
  logic [15:0] s = 16'h72b5, c, t, w;
  logic [7:0] q[$];
  int num_errors = 0, compares = 0;
  always #10 core_clk = ~core_clk;
  host_model host_model_i (.*);
  rx_status_and_layer4_crc rx_status_and_layer4_crc_i (.core_clk, .rst_b,
    .block_ready, .block_done, .vertical_corrected_flag(flags[7]),
    .block_sync_flag(flags[6]), .frame_sync_flag(flags[5]),
    .correction_failed(flags[4]), .layer2_error(flags[3]),
    .parity_block_flag(flags[2]), .frame_head_flag(flags[1]),
    .realtime_block_flag(flags[0]), .block_number_in, .interrupt_timing_option,
    .upper_layer_check_clear, .reg_addr, .reg_read, .reg_write, .reg_wdata,
    .reg_rdata, .serial_status_start, .serial_chip_enable, .serial_shift,
    .serial_out, .serial_status_done, .int_b, .upper_layer_check_ok);
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [15:0] crc(input logic [15:0] x,
                                      input logic [7:0] y);
    for (int b = 7; b >= 0; b--) begin
      x = {x[14:0], 1'b0} ^ ((x[15] ^ y[b]) ? CHECK_POLY : 16'h0000);
    end
    return x;
  endfunction : crc
  function automatic logic [7:0] stat(input logic [7:0] f);
    return {f[7:5], f[4] | f[3], f[2:1], 1'b1, f[0]};
  endfunction : stat
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
    compares++;
    if (y !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [7:0] x);
    q.push_back(x);
    host_model_i.cyc(a, 8'h00, 1'b0);
  endtask : rd
  task close_out();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  always @(posedge core_clk) begin
    if (pend) chk("reg_rdata", q.pop_front(), reg_rdata);
    pend <= reg_read;
  end
  initial begin
    #50000 num_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    rd(STATUS_ADDR, 8'h02);
    rd(BLOCK_NUMBER_ADDR, BLOCK_NUMBER_RESET);
    rd(4'h3, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      s = lfsr(s);
      @(posedge core_clk) #1 flags = s[7:0];
      e = (i > 1) ? {2'b00, s[13:8]} : 8'h00;
      block_number_in = (s[2] ? PARITY_BLOCK_MAX : DATA_BLOCK_MAX) - e;
      block_ready = 1'b1;
      w = {stat(flags), block_number_in};
      @(posedge core_clk) #1 block_ready = 1'b0;
      chk("int_b", 8'h00, {7'h00, int_b});
      {flags, block_number_in} = ~{flags, block_number_in};
      if (i[0]) rd(BLOCK_NUMBER_ADDR, w[7:0]);
      rd(STATUS_ADDR, w[15:8]);
      if (!i[0]) rd(BLOCK_NUMBER_ADDR, w[7:0]);
      @(posedge core_clk) #1 block_done = 1'b1;
      @(posedge core_clk) #1 block_done = 1'b0;
      chk("int_b", 8'h01, {7'h00, int_b});
    end
    s = lfsr(s);
    {interrupt_timing_option, flags} = {1'b1, s[7:0]};
    block_number_in = {2'b00, s[13:8]};
    repeat (2) @(posedge core_clk);
    rd(STATUS_ADDR, stat(flags));
    rd(BLOCK_NUMBER_ADDR, block_number_in);
    interrupt_timing_option = 1'b0;
    w = {stat(flags), block_number_in};
    $display("block tests done");
    host_model_i.cyc(CHECK_DATA_ADDR, 8'h5a, 1'b1);
    rd(STATUS_ADDR, w[15:8] & 8'hfd);
    host_model_i.clr();
    host_model_i.cyc(4'h5, 8'h5a, 1'b1);
    chk("check_ok", 8'h01, {7'h00, upper_layer_check_ok});
    c = CHECK_RESET;
    for (int j = 0; j < 5; j++) begin
      s = lfsr(s);
      if (j == 3) t = c;
      d = j < 3 ? s[7:0] : (j == 3 ? t[15:8] : t[7:0]);
      host_model_i.cyc(CHECK_DATA_ADDR, d, 1'b1);
      c = crc(c, d);
      e = {7'h00, c == 16'h0000};
      chk("check_ok", e, {7'h00, upper_layer_check_ok});
    end
    rd(STATUS_ADDR, w[15:8]);
    $display("check tests done");
    @(posedge core_clk) #1 {serial_chip_enable, serial_status_start} = 2'b11;
    @(posedge core_clk) #1 serial_status_start = 1'b0;
    @(posedge core_clk) #1;
    for (int k = 15; k >= 0; k--) begin
      chk("serial_out", {7'h00, w[k]}, {7'h00, serial_out});
      serial_shift = 1'b1;
      @(posedge core_clk) #1 serial_shift = 1'b0;
      @(posedge core_clk) #1;
    end
    chk("serial_done", 8'h01, {7'h00, serial_status_done});
    serial_chip_enable = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 {serial_chip_enable, serial_status_start} = 2'b11;
    @(posedge core_clk) #1 {serial_chip_enable, serial_status_start} = 2'b00;
    @(posedge core_clk) #1 {serial_chip_enable, serial_shift} = 2'b11;
    repeat (17) @(posedge core_clk);
    #1 chk("abort", 8'h00, {6'h00, serial_status_done, serial_out});
    {serial_chip_enable, serial_shift} = 2'b00;
    $display("serial test done");
    close_out();
  end
endmodule : tb_top
